/* bench/ext_pins.sv */
// Model of the external pins that feed the timer.
`timescale 1ns/100ps
module ext_pins (
  // Clock
  input  wire logic       clk_in,
  // Pin levels towards the timer
  output logic            clk_pin_out,
  output logic [3:0]      ch_pin_out
);
  // ==========
  // Pin drivers
  initial begin
    clk_pin_out = 1'b0;
    ch_pin_out  = 4'h0;
  end

  // Two cycles high and two low: a quarter of the bus rate, so the
  // clock stays well inside the half-rate limit of the input sampler.
  task automatic ext_pulses(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      clk_pin_out <= 1'b1;
      repeat (2) @(posedge clk_in);
      clk_pin_out <= 1'b0;
      @(posedge clk_in);
    end
  endtask

  // Each level is held two cycles so that a synchroniser cannot miss it.
  task automatic set_ch(input int i, input logic lvl);
    @(posedge clk_in);
    ch_pin_out[i] <= lvl;
    repeat (2) @(posedge clk_in);
  endtask
endmodule

/* bench/tb.sv */
// Testbench of the timer: register tests over APB and pin stimulus.
`timescale 1ns/100ps
module tb;
  import timer_pkg::*;
  // ==========
  // Signals
  logic        clk;
  logic        nrst;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [11:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        pready;
  logic        perr;
  logic        clk_pin;
  logic        dir_bit;
  logic        dat_bit;
  logic        cp_out;
  logic        cp_oe;
  logic [3:0]  ch_in;
  logic [3:0]  ch_out;
  logic [3:0]  ch_oe;
  logic        irq;
  int          err_count;
  int          cmp_count;
  logic [31:0] r;
  logic [15:0] v;
  logic [11:0] sca [4];

  timer_prescaler_capture_compare u_dut (
    .sys_clk_in(clk), .nrst_in(nrst), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr),
    .pwdata_in(wdata), .prdata_out(rdata), .pready_out(pready),
    .pslverr_out(perr), .clk_pin_in(clk_pin),
    .port_direction_bit_in(dir_bit), .port_data_bit_in(dat_bit),
    .clk_pin_out(cp_out), .clk_pin_oe_out(cp_oe), .ch_pin_in(ch_in),
    .ch_pin_out(ch_out), .ch_pin_oe_out(ch_oe), .irq_out(irq));

  ext_pins u_pins (.clk_in(clk), .clk_pin_out(clk_pin),
                   .ch_pin_out(ch_in));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ==========
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    psel  <= 1'b1;
    pwr   <= w;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) err_count++;
    q = rdata;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic chk_rng(input logic [15:0] g, input int lo, input int hi);
    logic ok;
    ok = (g >= lo) && (g <= hi);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    logic [31:0] q;
    rd(a, q);
    chk(q, e);
  endtask

  task automatic rdcnt(output logic [15:0] c);
    logic [31:0] h;
    logic [31:0] l;
    rd(ADDR_CNT_HIGH, h);
    rd(ADDR_CNT_LOW, l);
    c = {h[7:0], l[7:0]};
  endtask

  task automatic summarize();
    $display("errors=%0d compares=%0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========
  // Tests
  initial begin
    {nrst, psel, pen, pwr, dir_bit, dat_bit} = 6'h0;
    addr = 12'h0;
    wdata = 32'h0;
    err_count = 0;
    cmp_count = 0;
    sca = '{ADDR_CH0_SC, ADDR_CH1_SC, ADDR_CH2_SC, ADDR_CH3_SC};
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    chk({31'h0, irq}, 32'h0);
    rdchk(ADDR_CONTROL, 32'h0);
    for (int i = 0; i < 4; i++)
      rdchk(sca[i], {24'h0, SC_RESET});
    rdchk(12'h0FC, RD_ZERO);
    chk({31'h0, perr}, 32'h0);
    // The window between the start and stop writes is 260 cycles.
    for (int c = 0; c < 7; c++) begin
      wr(ADDR_CONTROL, 32'h30 | c);
      wr(ADDR_CONTROL, c);
      repeat (256) @(posedge clk);
      wr(ADDR_CONTROL, 32'h20 | c);
      rdcnt(v);
      chk_rng(v, (258 >> c) - 1, (262 >> c) + 1);
    end
    wr(ADDR_CONTROL, 32'h30);
    rd(ADDR_CNT_HIGH, r);
    wr(ADDR_CONTROL, 32'h00);
    repeat (100) @(posedge clk);
    rdchk(ADDR_CNT_HIGH, 32'h0);
    rdchk(ADDR_CNT_LOW, 32'h0);
    rd(ADDR_CNT_LOW, r);
    chk_rng({8'h0, r[7:0]}, 100, 140);
    wr(ADDR_CONTROL, 32'h30);
    rdcnt(v);
    chk({16'h0, v}, 32'h0);
    wr(ADDR_CMP_BASE, 32'h20);
    wr(ADDR_CH0_SC, 32'h50);
    wr(ADDR_CONTROL, 32'h00);
    repeat (200) if (irq !== 1'b1) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    chk({28'h0, ch_oe}, 32'h1);
    wr(ADDR_CONTROL, 32'h20);
    rdchk(ADDR_CH0_SC, 32'hD0);
    wr(ADDR_CH0_SC, 32'hD0);
    rdchk(ADDR_CH0_SC, 32'hD0);
    wr(ADDR_CH0_SC, 32'h50);
    rdchk(ADDR_CH0_SC, 32'h50);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_CH1_SC, 32'h04);
    u_pins.set_ch(1, 1'b1);
    repeat (4) @(posedge clk);
    rdchk(ADDR_CH1_SC, 32'h84);
    chk({31'h0, irq}, 32'h0);
    u_pins.set_ch(1, 1'b0);
    u_pins.set_ch(1, 1'b1);
    repeat (4) @(posedge clk);
    wr(ADDR_CH1_SC, 32'h04);
    rdchk(ADDR_CH1_SC, 32'h84);
    wr(ADDR_CH1_SC, 32'h04);
    rdchk(ADDR_CH1_SC, 32'h04);
    wr(ADDR_CONTROL, 32'h30);
    wr(ADDR_CMP_BASE + 12'h004, 32'h10);
    wr(ADDR_CH2_SC, 32'h14);
    wr(ADDR_CONTROL, 32'h00);
    repeat (40) @(posedge clk);
    chk({28'h0, ch_out}, 32'h4);
    chk({28'h0, ch_oe}, 32'h5);
    dir_bit <= 1'b1;
    dat_bit <= 1'b1;
    repeat (3) @(posedge clk);
    chk({30'h0, cp_oe, cp_out}, 32'h3);
    wr(ADDR_CONTROL, 32'h37);
    wr(ADDR_CONTROL, 32'h07);
    repeat (2) @(posedge clk);
    chk({31'h0, cp_oe}, 32'h0);
    u_pins.ext_pulses(10);
    repeat (5) @(posedge clk);
    wr(ADDR_CONTROL, 32'h27);
    rdcnt(v);
    chk({16'h0, v}, 32'd10);
    summarize();
  end

  // A hang is cut short well after the tests' expected span.
  initial begin
    #200000;
    err_count++;
    summarize();
  end
endmodule

/* include/timer_pkg.sv */
// Package with register map, field layout and reset values of the timer.
package timer_pkg;

  // ==========================================================================
  // Register byte addresses (one aligned word each; compare and capture bases start four 16-bit entries at two-byte steps)
  localparam logic [11:0] ADDR_CONTROL   = 12'h000;
  localparam logic [11:0] ADDR_CNT_HIGH  = 12'h004;
  localparam logic [11:0] ADDR_CNT_LOW   = 12'h008;
  localparam logic [11:0] ADDR_CH0_SC    = 12'h010;
  localparam logic [11:0] ADDR_CH1_SC    = 12'h014;
  localparam logic [11:0] ADDR_CH2_SC    = 12'h02C;
  localparam logic [11:0] ADDR_CH3_SC    = 12'h01C;
  localparam logic [11:0] ADDR_CMP_BASE  = 12'h040;
  localparam logic [11:0] ADDR_CAP_BASE  = 12'h060;

  // ==========================================================================
  // Control register fields
  localparam int PS_LSB       = 0;
  localparam int CNT_RST_BIT  = 4;
  localparam int CNT_STOP_BIT = 5;
  localparam logic [2:0] PS_EXTERNAL = 3'h7;
  localparam logic [2:0] PS_RESET    = 3'h0;

  // ==========================================================================
  // Channel status/control byte fields
  localparam int FLAG_BIT  = 7;
  localparam int IE_BIT    = 6;
  localparam int MSB_BIT   = 5;
  localparam int MSA_BIT   = 4;
  localparam int ELSB_BIT  = 3;
  localparam int ELSA_BIT  = 2;
  localparam int TOV_BIT   = 1;
  localparam int MAX_BIT   = 0;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] SC_WMASK = 8'h7F;

  localparam logic [31:0] RD_ZERO = 32'h0000_0000;

endpackage

/* rtl/timer_prescaler_capture_compare.sv */
// Timer with prescaler, coherent counter read and four capture/compare pins.
// Function
// - Select field picks bus clock divided 1..64, or external clock pin.
// - Reset clears the select field so counter runs undivided.
// - Selected as clock source, the shared pin is input regardless of direction.
// - Otherwise the shared pin is an ordinary port pin.
// - Each channel pin is independently input capture or output compare.
// - Channels one and two also offer buffered compare and buffered PWM.
// - High byte read latches the low byte into a holding buffer.
// - Further high reads keep the latch; low byte read releases it.
// - Counter clears on reset and when software sets counter reset bit.
// - Capture channel sets its flag on an active pin edge.
// - Compare channel sets its flag when counter equals compare value.
// - Flag clears only after read-while-set followed by writing zero.
// - An event between status read and zero write voids the clear.
// - Writing one to a flag has no effect; reset clears all flags.
// - Per-channel enable gates that channel's interrupt; reset disables.
// - Status byte holds flag in bit 7, enable in bit 6, resets zero.
`timescale 1ns/100ps
module timer_prescaler_capture_compare
  import timer_pkg::*;
#(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        nrst_in,
  // APB slave
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  // Shared clock pin and its port function
  input  wire logic        clk_pin_in,
  input  wire logic        port_direction_bit_in,
  input  wire logic        port_data_bit_in,
  output logic             clk_pin_out,
  output logic             clk_pin_oe_out,
  // Channel pins
  input  wire logic [3:0]  ch_pin_in,
  output logic      [3:0]  ch_pin_out,
  output logic      [3:0]  ch_pin_oe_out,
  // Interrupt
  output logic             irq_out
);

  // The field layout and the interrupt merge are built for four channels.
  if (CHANNELS != 4) begin : g_bad_channels
    $error("CHANNELS must be 4");
  end

  typedef struct packed {
    logic [2:0]       clock_source_select;
    logic             stop;
    logic [15:0]      count;
    logic [5:0]       div;
    logic             ext_prev;
    logic             ext_sync;
    logic [7:0]       low_hold;
    logic             latched;
    logic [3:0][7:0]  sc;
    logic [3:0][15:0] cmp;
    logic [3:0][15:0] cmp_buf;
    logic [3:0][15:0] cap;
    logic [3:0]       pin_prev;
    logic [3:0]       pin_lvl;
    logic [3:0]       armed;
    logic [31:0]      rdata;
    logic             ready;
    logic             irq;
    logic             pin_o;
    logic             pin_oe;
    logic [3:0]       ch_o;
    logic [3:0]       ch_oe;
  } state_type;

  state_type s_q;
  state_type s_d;

  logic        tick;
  logic        wr_acc;
  logic        rd_acc;
  logic [1:0]  ch_idx;
  logic        ch_hit;
  logic        cmp_hit;
  logic        cap_hit;
  logic [15:0] next_count;
  logic        wrapped;
  logic [3:0]  ev_hit;

  // ==========================================================================
  // Prescaler and counter
  always_comb begin
    wr_acc = psel_in && penable_in && !s_q.ready && pwrite_in;
    rd_acc = psel_in && penable_in && !s_q.ready && !pwrite_in;
    ch_idx = paddr_in[3:2];
    ch_hit = (paddr_in == ADDR_CH0_SC) || (paddr_in == ADDR_CH1_SC) ||
             (paddr_in == ADDR_CH2_SC) || (paddr_in == ADDR_CH3_SC);
    if (paddr_in == ADDR_CH2_SC) begin
      ch_idx = 2'h2;
    end
    cmp_hit = (paddr_in[11:5] == ADDR_CMP_BASE[11:5]) && (paddr_in[4:3] == 2'h0);
    cap_hit = (paddr_in[11:5] == ADDR_CAP_BASE[11:5]) && (paddr_in[4:3] == 2'h0);
    // Divider taps: code n ticks every 2**n bus cycles.
    case (s_q.clock_source_select)
      3'h0:    tick = 1'b1;
      3'h1:    tick = (s_q.div[0] == 1'b1);
      3'h2:    tick = (s_q.div[1:0] == 2'h3);
      3'h3:    tick = (s_q.div[2:0] == 3'h7);
      3'h4:    tick = (s_q.div[3:0] == 4'hF);
      3'h5:    tick = (s_q.div[4:0] == 5'h1F);
      3'h6:    tick = (s_q.div == 6'h3F);
      default: tick = s_q.ext_sync && !s_q.ext_prev;
    endcase
    if (s_q.stop) begin
      tick = 1'b0;
    end
    next_count = s_q.count + 16'h0001;
    wrapped    = tick && (s_q.count == 16'hFFFF);
  end

  always_comb begin
    s_d       = s_q;
    ev_hit    = 4'h0;
    s_d.ready = 1'b0;
    s_d.rdata = RD_ZERO;
    s_d.div   = s_q.div + 6'h01;
    // The external clock pin is only sampled, so it must be slower than half
    // the bus clock or edges are missed.
    s_d.ext_sync = clk_pin_in;
    s_d.ext_prev = s_q.ext_sync;
    if (tick) begin
      s_d.count = next_count;
    end
    // Pin drive: input when it clocks the counter, else plain port.
    s_d.pin_oe = (s_q.clock_source_select != PS_EXTERNAL) &&
                 port_direction_bit_in;
    s_d.pin_o  = port_data_bit_in;

    // Channel events; set takes priority over any clear below.
    for (int i = 0; i < 4; i++) begin
      s_d.pin_lvl[i]  = ch_pin_in[i];
      s_d.pin_prev[i] = s_q.pin_lvl[i];
    end

    // Register access.
    if (psel_in && penable_in && !s_q.ready) begin
      s_d.ready = 1'b1;
    end
    if (rd_acc) begin
      if (paddr_in == ADDR_CONTROL) begin
        s_d.rdata = {26'h0, s_q.stop, 1'b0, 1'b0, s_q.clock_source_select};
      end else if (paddr_in == ADDR_CNT_HIGH) begin
        s_d.rdata = {24'h0, s_q.count[15:8]};
        if (!s_q.latched) begin
          s_d.low_hold = s_q.count[7:0];
          s_d.latched  = 1'b1;
        end
      end else if (paddr_in == ADDR_CNT_LOW) begin
        // A skipped low read leaves the stale byte held.
        s_d.rdata   = {24'h0, s_q.latched ? s_q.low_hold : s_q.count[7:0]};
        s_d.latched = 1'b0;
      end else if (ch_hit) begin
        s_d.rdata = {24'h0, s_q.sc[ch_idx]};
        s_d.armed[ch_idx] = s_q.sc[ch_idx][FLAG_BIT];
      end else if (cmp_hit) begin
        s_d.rdata = {16'h0, s_q.cmp[paddr_in[2:1] & 2'h3]};
      end else if (cap_hit) begin
        s_d.rdata = {16'h0, s_q.cap[paddr_in[2:1] & 2'h3]};
      end
    end
    if (wr_acc) begin
      if (paddr_in == ADDR_CONTROL) begin
        s_d.clock_source_select = pwdata_in[PS_LSB+:3];
        s_d.stop = pwdata_in[CNT_STOP_BIT];
        if (pwdata_in[CNT_RST_BIT]) begin
          s_d.count = 16'h0000;
          s_d.div   = 6'h00;
        end
      end else if (ch_hit) begin
        s_d.sc[ch_idx] = (s_q.sc[ch_idx] & ~SC_WMASK) |
                         (pwdata_in[7:0] & SC_WMASK);
        // Only a zero after an armed read clears; a one is ignored.
        if (!pwdata_in[FLAG_BIT] && s_q.armed[ch_idx]) begin
          s_d.sc[ch_idx][FLAG_BIT] = 1'b0;
        end
        s_d.armed[ch_idx] = 1'b0;
      end else if (cmp_hit) begin
        s_d.cmp_buf[paddr_in[2:1] & 2'h3] = pwdata_in[15:0];
        if (!s_q.sc[paddr_in[2:1] & 2'h3][MSB_BIT]) begin
          s_d.cmp[paddr_in[2:1] & 2'h3] = pwdata_in[15:0];
        end
      end
    end

    for (int i = 0; i < 4; i++) begin
      logic mode_cmp;
      logic edge_hit;
      logic cmp_eq;
      mode_cmp = s_q.sc[i][MSA_BIT] || s_q.sc[i][MSB_BIT];
      edge_hit = (s_q.sc[i][ELSA_BIT] && !s_q.pin_prev[i] && s_q.pin_lvl[i])
              || (s_q.sc[i][ELSB_BIT] && s_q.pin_prev[i] && !s_q.pin_lvl[i]);
      cmp_eq   = tick && (next_count == s_q.cmp[i]);
      ev_hit[i] = (!mode_cmp && edge_hit) || (mode_cmp && cmp_eq);
      if (!mode_cmp && edge_hit) begin
        s_d.cap[i] = s_q.count;
        s_d.sc[i][FLAG_BIT] = 1'b1;
        s_d.armed[i] = 1'b0;
      end
      if (mode_cmp && cmp_eq) begin
        s_d.sc[i][FLAG_BIT] = 1'b1;
        s_d.armed[i] = 1'b0;
      end
      // Buffered modes load the new compare value at overflow, so PWM
      // edges never tear mid-period; only channels one and two.
      if ((i == 1 || i == 2) && s_q.sc[i][MSB_BIT] && wrapped) begin
        s_d.cmp[i] = s_q.cmp_buf[i];
      end
    end
    // Compare outputs: a match acts per the edge/level code, and overflow
    // may toggle the pin.  The full-duty bit suppresses the match action so
    // a PWM output can stay at one level for a whole period.
    for (int i = 0; i < 4; i++) begin
      s_d.ch_oe[i] = s_q.sc[i][MSA_BIT] || s_q.sc[i][MSB_BIT];
      if ((s_q.sc[i][MSA_BIT] || s_q.sc[i][MSB_BIT]) && tick) begin
        if (next_count == s_q.cmp[i] && !s_q.sc[i][MAX_BIT]) begin
          case ({s_q.sc[i][ELSB_BIT], s_q.sc[i][ELSA_BIT]})
            2'h1:    s_d.ch_o[i] = ~s_q.ch_o[i];
            2'h2:    s_d.ch_o[i] = 1'b0;
            2'h3:    s_d.ch_o[i] = 1'b1;
            default: s_d.ch_o[i] = s_q.ch_o[i];
          endcase
        end else if (wrapped && s_q.sc[i][TOV_BIT]) begin
          s_d.ch_o[i] = ~s_q.ch_o[i];
        end
      end
    end

    s_d.irq = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (s_d.sc[i][FLAG_BIT] && s_d.sc[i][IE_BIT]) begin
        s_d.irq = 1'b1;
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ch_pin_out     = s_q.ch_o;
  assign ch_pin_oe_out  = s_q.ch_oe;
  assign prdata_out     = s_q.rdata;
  assign pready_out     = s_q.ready;
  assign pslverr_out    = 1'b0;
  assign irq_out        = s_q.irq;
  assign clk_pin_out    = s_q.pin_o;
  assign clk_pin_oe_out = s_q.pin_oe;

  // ==========================================================================
  // Assertions
  sequence high_read_s;
    rd_acc && paddr_in == ADDR_CNT_HIGH && !s_q.latched;
  endsequence

  AST_PS_RESET: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(nrst_in) |-> s_q.clock_source_select == PS_RESET)
    else $error("select not cleared by reset");
  AST_LATCH: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    high_read_s |=> s_q.latched && s_q.low_hold == $past(s_q.count[7:0]))
    else $error("low byte not latched");
  AST_HOLD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.latched && !(rd_acc && paddr_in == ADDR_CNT_LOW) |=>
    $stable(s_q.low_hold) && s_q.latched)
    else $error("latched low byte changed");
  AST_CNT_RST: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_acc && paddr_in == ADDR_CONTROL && pwdata_in[CNT_RST_BIT]
    |=> s_q.count == 16'h0000)
    else $error("counter not cleared");
  AST_COUNT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tick && !wr_acc |=> s_q.count == $past(s_q.count) + 16'h0001)
    else $error("counter did not step");
  AST_PIN_IN: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.clock_source_select == PS_EXTERNAL ##1
    s_q.clock_source_select == PS_EXTERNAL |-> !clk_pin_oe_out)
    else $error("clock pin driven while clock source");
  AST_NO_CLR_ONE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.sc[2][FLAG_BIT] && !s_q.armed[2] |=> s_q.sc[2][FLAG_BIT])
    else $error("flag cleared without read");
  AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    irq_out == |{s_q.sc[0][7] & s_q.sc[0][6], s_q.sc[1][7] & s_q.sc[1][6],
                 s_q.sc[2][7] & s_q.sc[2][6], s_q.sc[3][7] & s_q.sc[3][6]})
    else $error("interrupt does not match flags");
  AST_TICK1: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.clock_source_select == 3'h1 && !s_q.stop && tick |=> !tick)
    else $error("divide by two wrong");
  AST_TICK64: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.clock_source_select == 3'h6 && tick |=> !tick)
    else $error("divide by sixty-four wrong");
  AST_WRAP: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    tick && !wr_acc && s_q.count == 16'hFFFF |=> s_q.count == 16'h0000)
    else $error("counter did not wrap");
  AST_SC_RESET: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    $rose(nrst_in) |-> s_q.sc == 32'h0000_0000)
    else $error("status bytes not cleared by reset");
  AST_HIGH_DATA: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_acc && paddr_in == ADDR_CNT_HIGH |=>
    prdata_out[7:0] == $past(s_q.count[15:8]))
    else $error("high byte read wrong");
  AST_RELEASE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    rd_acc && paddr_in == ADDR_CNT_LOW |=> !s_q.latched)
    else $error("low byte not released");
  AST_PIN_PORT: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.clock_source_select != PS_EXTERNAL |=>
    clk_pin_oe_out == $past(port_direction_bit_in) &&
    clk_pin_out == $past(port_data_bit_in))
    else $error("clock pin not a plain port pin");
  AST_CH_OE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    1'b1 |=> ch_pin_oe_out[0] ==
    $past(s_q.sc[0][MSA_BIT] || s_q.sc[0][MSB_BIT]))
    else $error("channel drive does not follow mode");

  // ==========================================================================
  // Flag handshake assertions, checked on channel one; the compare flag on channel zero
  sequence cap_rise1_s;
    !(s_q.sc[1][MSA_BIT] || s_q.sc[1][MSB_BIT]) && s_q.sc[1][ELSA_BIT] &&
    !s_q.pin_prev[1] && s_q.pin_lvl[1];
  endsequence

  sequence armed_clear1_s;
    wr_acc && paddr_in == ADDR_CH1_SC && !pwdata_in[FLAG_BIT] &&
    s_q.armed[1] && !ev_hit[1];
  endsequence

  AST_CAP_FLAG: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    cap_rise1_s |=> s_q.sc[1][FLAG_BIT])
    else $error("capture edge did not set flag");
  AST_CMP_FLAG: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    (s_q.sc[0][MSA_BIT] || s_q.sc[0][MSB_BIT]) && tick &&
    next_count == s_q.cmp[0] |=> s_q.sc[0][FLAG_BIT])
    else $error("compare match did not set flag");
  AST_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    armed_clear1_s |=> !s_q.sc[1][FLAG_BIT])
    else $error("armed zero write did not clear flag");
  AST_EV_WINS: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    ev_hit[1] |=> s_q.sc[1][FLAG_BIT] && !s_q.armed[1])
    else $error("event did not void the pending clear");
  AST_FLAG_ONE: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    wr_acc && paddr_in == ADDR_CH1_SC && pwdata_in[FLAG_BIT] &&
    s_q.sc[1][FLAG_BIT] |=> s_q.sc[1][FLAG_BIT])
    else $error("writing one changed the flag");

  // Buffered compare: the shadow value lands only at overflow, so a
  // mid-period write never shortens the running pulse.
  AST_BUF_LOAD: assert property (@(posedge sys_clk_in) disable iff (!nrst_in)
    s_q.sc[1][MSB_BIT] && wrapped |=>
    s_q.cmp[1] == $past(s_q.cmp_buf[1]))
    else $error("buffered compare not loaded at overflow");

endmodule
